// ===== watchdog_control_defs.vh
// Register map, field layout and timing constants of the operating watchdog.
`ifndef WATCHDOG_CONTROL_DEFS_VH
`define WATCHDOG_CONTROL_DEFS_VH

`define WD_ADDR_W        8
`define WD_DATA_W        8

`define WD_CTL_OFF       8'h3c
`define WD_SVC_OFF       8'h3f
`define WD_CFG_OFF       8'h40
`define WD_STAT_OFF      8'h41
`define WD_MASK_OFF      8'h42

`define WD_CTL_WIN_BIT   7
`define WD_CTL_DBG_BIT   6
`define WD_CTL_WMASK_BIT 5
`define WD_CTL_RATE_HI   2
`define WD_CTL_RATE_LO   0

`define WD_CFG_SEL_BIT   0
`define WD_CFG_RUN_BIT   1
`define WD_CFG_EFF_BIT   2

`define WD_EV_W          3
`define WD_EV_TIMEOUT    0
`define WD_EV_BADKEY     1
`define WD_EV_EARLY      2

`define WD_RATE_OFF      3'h0
`define WD_KEY_ARM       8'h55
`define WD_KEY_FIRE      8'haa

`define WD_SHIFT_W       5
`define WD_SHIFT_1       5'h0e
`define WD_SHIFT_2       5'h10
`define WD_SHIFT_3       5'h12
`define WD_SHIFT_4       5'h14
`define WD_SHIFT_5       5'h16
`define WD_SHIFT_6       5'h17
`define WD_SHIFT_7       5'h18
`define WD_SHIFT_MAX     5'h18
`define WD_CNT_W         24

`endif

// ===== pin_sync.v
// Three-stage synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/1ps
module pin_sync
(
  input  wire ref_clk,
  input  wire rst,
  input  wire pin,
  output reg  level_q,
  output reg  rise_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end
    else
    begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_q <= 1'b0;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
        rise_q  <= s3_q & ~level_q;
      end
    end
  end

endmodule // pin_sync

// ===== wd_counter.v
// Timeout counter that counts counter-clock ticks up to a power-of-two period.
`timescale 1ns/1ps
`include "watchdog_control_defs.vh"
module wd_counter
#(
  parameter CNT_W = `WD_CNT_W
)
(
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire                   restart,
  input  wire                   tick,
  input  wire                   run,
  input  wire [`WD_SHIFT_W-1:0] shift,
  output reg                    timeout_q,
  output wire                   late
);

  reg  [CNT_W-1:0] count_q;
  wire [CNT_W:0]   period;
  wire [CNT_W:0]   last;
  wire [CNT_W:0]   quarter;

  assign period  = {{CNT_W{1'b0}}, 1'b1} << shift;
  assign last    = period - {{CNT_W{1'b0}}, 1'b1};
  assign quarter = period >> 2;
  // In window mode, servicing is only legal once three quarters of the period have elapsed.
  assign late    = {1'b0, count_q} >= (period - quarter);

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_q   <= {CNT_W{1'b0}};
      timeout_q <= 1'b0;
    end
    else
    begin
      timeout_q <= 1'b0;
      if (restart || !run)
      begin
        count_q <= {CNT_W{1'b0}};
      end
      else if (tick)
      begin
        if ({1'b0, count_q} == last)
        begin
          count_q   <= {CNT_W{1'b0}};
          timeout_q <= 1'b1;
        end
        else
        begin
          count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // wd_counter

// ===== watchdog_control.v
// Operating watchdog: control register permissions, servicing, timeout and reset request.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "watchdog_control_defs.vh"
module watchdog_control
#(
  parameter SHIFT_REDUCE = 0
)
(
  input  wire                   ref_clk,
  input  wire                   rst,
  input  wire [`WD_ADDR_W-1:0]  addr,
  input  wire [`WD_DATA_W-1:0]  wr_data,
  input  wire                   wr_en,
  input  wire                   rd_en,
  output reg  [`WD_DATA_W-1:0]  rd_data_q,
  input  wire                   special_mode,
  input  wire                   stop_mode,
  input  wire                   pseudo_stop_select,
  input  wire                   background_debug,
  input  wire                   internal_rc_clock,
  input  wire                   oscillator_clock,
  input  wire                   oscillator_ok_status,
  input  wire                   flash_window_mode,
  input  wire [2:0]             flash_rate_select,
  output reg                    wd_reset_q,
  output reg                    irq_q
);

  reg                   window_mode_q;
  reg                   stop_in_debug_q;
  reg [2:0]             rate_select_q;
  reg                   once_used_q;
  reg                   clock_source_select_q;
  reg                   stop_run_enable_q;
  reg                   eff_sel_q;
  reg                   loaded_q;
  reg                   armed_q;
  reg [`WD_EV_W-1:0]    status_q;
  reg [`WD_EV_W-1:0]    mask_q;

  reg                   window_mode_d;
  reg                   stop_in_debug_d;
  reg [2:0]             rate_select_d;
  reg                   once_used_d;
  reg                   ctl_restart;
  reg [`WD_SHIFT_W-1:0] shift_raw;
  reg [`WD_DATA_W-1:0]  rd_mux;

  wire                  rc_level;
  wire                  rc_rise;
  wire                  osc_level;
  wire                  osc_rise;
  wire                  osc_ok;
  wire                  eff_sel_d;
  wire                  sel_change;
  wire                  tick;
  wire                  halted;
  wire                  enabled;
  wire                  debug_override;
  wire                  window_eff;
  wire [`WD_SHIFT_W-1:0] shift_eff;
  wire                  timeout;
  wire                  late;
  wire                  ctl_wr;
  wire                  svc_wr;
  wire                  cfg_wr;
  wire                  stat_wr;
  wire                  mask_wr;
  wire                  field_ok;
  wire                  svc_bad;
  wire                  svc_early;
  wire                  svc_fire;
  wire                  flash_start;
  wire                  restart;
  wire [`WD_EV_W-1:0]   events;

  pin_sync u_rc_sync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (internal_rc_clock),
    .level_q (rc_level),
    .rise_q  (rc_rise)
  );

  pin_sync u_osc_sync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (oscillator_clock),
    .level_q (osc_level),
    .rise_q  (osc_rise)
  );

  pin_sync u_ok_sync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (oscillator_ok_status),
    .level_q (osc_ok),
    .rise_q  ()
  );

  // Losing the oscillator falls back to the RC clock, which counts as a source change.
  assign eff_sel_d  = clock_source_select_q & osc_ok;
  assign sel_change = loaded_q && (eff_sel_d != eff_sel_q);
  assign tick       = eff_sel_q ? osc_rise : rc_rise;

  assign halted = (stop_mode && !(pseudo_stop_select && eff_sel_q && stop_run_enable_q))
                  || (background_debug && stop_in_debug_q);

  assign enabled        = loaded_q && (rate_select_q != `WD_RATE_OFF);
  assign debug_override = enabled && background_debug && !stop_in_debug_q && special_mode;
  assign window_eff     = window_mode_q && !debug_override;

  always @*
  begin
    case (rate_select_q)
      3'h1:    shift_raw = `WD_SHIFT_1;
      3'h2:    shift_raw = `WD_SHIFT_2;
      3'h3:    shift_raw = `WD_SHIFT_3;
      3'h4:    shift_raw = `WD_SHIFT_4;
      3'h5:    shift_raw = `WD_SHIFT_5;
      3'h6:    shift_raw = `WD_SHIFT_6;
      3'h7:    shift_raw = `WD_SHIFT_7;
      default: shift_raw = `WD_SHIFT_MAX;
    endcase
  end

  // The reduction only exists so that simulation can shorten the long periods.
  assign shift_eff = (debug_override ? `WD_SHIFT_MAX : shift_raw) - SHIFT_REDUCE[`WD_SHIFT_W-1:0];

  assign ctl_wr  = wr_en && (addr == `WD_CTL_OFF);
  assign svc_wr  = wr_en && (addr == `WD_SVC_OFF) && enabled;
  assign cfg_wr  = wr_en && (addr == `WD_CFG_OFF);
  assign stat_wr = wr_en && (addr == `WD_STAT_OFF);
  assign mask_wr = wr_en && (addr == `WD_MASK_OFF);

  assign field_ok = ctl_wr && !wr_data[`WD_CTL_WMASK_BIT] && (special_mode || !once_used_q);

  always @*
  begin
    window_mode_d   = window_mode_q;
    stop_in_debug_d = stop_in_debug_q;
    rate_select_d   = rate_select_q;
    once_used_d     = once_used_q;
    ctl_restart     = 1'b0;
    if (ctl_wr)
    begin
      if (special_mode)
      begin
        stop_in_debug_d = wr_data[`WD_CTL_DBG_BIT];
        ctl_restart     = 1'b1;
        if (field_ok)
        begin
          window_mode_d = wr_data[`WD_CTL_WIN_BIT];
          rate_select_d = wr_data[`WD_CTL_RATE_HI:`WD_CTL_RATE_LO];
        end
      end
      else
      begin
        stop_in_debug_d = stop_in_debug_q | wr_data[`WD_CTL_DBG_BIT];
        if (!stop_in_debug_q && wr_data[`WD_CTL_DBG_BIT])
        begin
          ctl_restart = 1'b1;
        end
        if (field_ok)
        begin
          once_used_d = 1'b1;
          if (wr_data[`WD_CTL_WIN_BIT])
          begin
            window_mode_d = 1'b1;
            ctl_restart   = 1'b1;
          end
          if (wr_data[`WD_CTL_RATE_HI:`WD_CTL_RATE_LO] != `WD_RATE_OFF)
          begin
            rate_select_d = wr_data[`WD_CTL_RATE_HI:`WD_CTL_RATE_LO];
            ctl_restart   = 1'b1;
          end
        end
      end
    end
  end

  assign svc_early = svc_wr && window_eff && !late;
  assign svc_bad   = svc_wr && (wr_data != `WD_KEY_ARM) && (wr_data != `WD_KEY_FIRE);
  assign svc_fire  = svc_wr && armed_q && (wr_data == `WD_KEY_FIRE) && !svc_early;

  assign flash_start = !loaded_q && (flash_rate_select != `WD_RATE_OFF);
  assign restart     = ctl_restart || sel_change || svc_fire || flash_start;

  wd_counter #(.CNT_W(`WD_CNT_W)) u_counter
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .restart   (restart),
    .tick      (tick),
    .run       (enabled && !halted),
    .shift     (shift_eff),
    .timeout_q (timeout),
    .late      (late)
  );

  assign events = {svc_early, svc_bad, timeout && enabled};

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      window_mode_q         <= 1'b0;
      stop_in_debug_q       <= 1'b0;
      rate_select_q         <= `WD_RATE_OFF;
      once_used_q           <= 1'b0;
      clock_source_select_q <= 1'b0;
      stop_run_enable_q     <= 1'b0;
      eff_sel_q             <= 1'b0;
      loaded_q              <= 1'b0;
      armed_q               <= 1'b0;
      status_q              <= {`WD_EV_W{1'b0}};
      mask_q                <= {`WD_EV_W{1'b0}};
      wd_reset_q            <= 1'b0;
      irq_q                 <= 1'b0;
    end
    else
    begin
      loaded_q  <= 1'b1;
      eff_sel_q <= eff_sel_d;
      if (!loaded_q)
      begin
        // Flash values are taken on the first edge after release, never under reset.
        window_mode_q <= flash_window_mode;
        rate_select_q <= flash_rate_select;
      end
      else
      begin
        window_mode_q   <= window_mode_d;
        stop_in_debug_q <= stop_in_debug_d;
        rate_select_q   <= rate_select_d;
        once_used_q     <= once_used_d;
      end
      if (cfg_wr)
      begin
        clock_source_select_q <= wr_data[`WD_CFG_SEL_BIT];
        stop_run_enable_q     <= wr_data[`WD_CFG_RUN_BIT];
      end
      if (mask_wr)
      begin
        mask_q <= wr_data[`WD_EV_W-1:0];
      end
      // A set in the same cycle as a write-one clear keeps the bit set.
      status_q <= (status_q & ~(stat_wr ? wr_data[`WD_EV_W-1:0] : {`WD_EV_W{1'b0}})) | events;
      irq_q    <= |(status_q & mask_q);
      wd_reset_q <= |events;
      if (svc_fire || restart || !enabled)
      begin
        armed_q <= 1'b0;
      end
      else if (svc_wr && (wr_data == `WD_KEY_ARM))
      begin
        armed_q <= 1'b1;
      end
    end
  end

  always @*
  begin
    case (addr)
      `WD_CTL_OFF:  rd_mux = {window_mode_q, stop_in_debug_q, 3'h0, rate_select_q};
      `WD_CFG_OFF:  rd_mux = {5'h00, eff_sel_q, stop_run_enable_q, clock_source_select_q};
      `WD_STAT_OFF: rd_mux = {5'h00, status_q};
      `WD_MASK_OFF: rd_mux = {5'h00, mask_q};
      default:      rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_data_q <= rd_en ? rd_mux : 8'h00;
    end
  end

endmodule // watchdog_control

// ===== watchdog_control_checker.sv
// Concurrent checks on the ports of the watchdog control block.
`timescale 1ns/1ps
`include "watchdog_control_defs.vh"
module watchdog_control_checker
#(
  parameter SHIFT_REDUCE = 0
)
(
  input wire                  ref_clk,
  input wire                  rst,
  input wire [`WD_ADDR_W-1:0] addr,
  input wire [`WD_DATA_W-1:0] wr_data,
  input wire                  wr_en,
  input wire                  rd_en,
  input wire [`WD_DATA_W-1:0] rd_data_q,
  input wire                  special_mode,
  input wire                  stop_mode,
  input wire                  pseudo_stop_select,
  input wire                  wd_reset_q,
  input wire                  irq_q
);
  reg       mask_wr_q;
  reg       mask_wr_qq;
  reg [7:0] wd_q;
  reg [7:0] wd_qq;
  // Delayed copies keep past mask writes and write data plain signals; rd_en and wd_reset_q still use $past.
  always @(posedge ref_clk)
  begin
    mask_wr_q  <= wr_en && addr == `WD_MASK_OFF;
    mask_wr_qq <= mask_wr_q;
    wd_q       <= wr_data;
    wd_qq      <= wd_q;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_ctl_rd;
    rd_en && addr == `WD_CTL_OFF;
  endsequence
  sequence s_special_wr;
    special_mode && wr_en && addr == `WD_CTL_OFF && !wr_data[`WD_CTL_WMASK_BIT];
  endsequence
  sequence s_normal_dbg_wr;
    !special_mode && wr_en && addr == `WD_CTL_OFF && wr_data[`WD_CTL_DBG_BIT];
  endsequence
  sequence s_halted;
    (stop_mode && !pseudo_stop_select && !wr_en)[*4];
  endsequence
  property p_rd_idle; !$past(rd_en) |-> rd_data_q == 8'h00; endproperty
  property p_ctl_zero; s_ctl_rd |=> rd_data_q[5:3] == 3'h0; endproperty
  property p_svc_zero; rd_en && addr == `WD_SVC_OFF |=> rd_data_q == 8'h00; endproperty
  property p_special_rw;
    s_special_wr ##1 s_ctl_rd |=> rd_data_q[7] == wd_qq[7] && rd_data_q[6] == wd_qq[6] && rd_data_q[2:0] == wd_qq[2:0];
  endproperty
  property p_dbg_set; s_normal_dbg_wr ##1 s_ctl_rd |=> rd_data_q[6]; endproperty
  property p_reset_pulse; wd_reset_q && !wr_en |=> !wd_reset_q; endproperty
  property p_stop_halt; s_halted |-> !wd_reset_q; endproperty
  property p_irq_src; $rose(irq_q) |-> $past(wd_reset_q) || mask_wr_qq; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
  a_ctl_zero: assert property (p_ctl_zero) else $error("control bits 5 to 3 not zero");
  a_svc_zero: assert property (p_svc_zero) else $error("service register read not zero");
  a_special_rw: assert property (p_special_rw) else $error("special write not read back");
  a_dbg_set: assert property (p_dbg_set) else $error("stop in debug not set");
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request longer than one cycle");
  a_stop_halt: assert property (p_stop_halt) else $error("reset request while halted");
  a_irq_src: assert property (p_irq_src) else $error("interrupt rose without cause");
endmodule // watchdog_control_checker
bind watchdog_control watchdog_control_checker #(.SHIFT_REDUCE(SHIFT_REDUCE)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .special_mode(special_mode),
  .stop_mode(stop_mode), .pseudo_stop_select(pseudo_stop_select), .wd_reset_q(wd_reset_q), .irq_q(irq_q));

// ===== tb_top.sv
// Self-checking bench for the watchdog control block.
`timescale 1ns/1ps
`include "watchdog_control_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  reg        ref_clk = 0, rst = 1, wr_en = 0, rd_en = 0, sp = 0, stp = 0, rc = 0, osc = 0;
  reg  [7:0] addr = 0, wr_data = 0, d = 0, e = 0;
  reg  [3:0] fl = 0;
  reg        ps = 0, ok = 1;
  wire [7:0] rdq;
  wire       wdr, irq;
  integer    n_errors = 0, num_checks = 0, cyc = 0, n = 0, np = 0, i = 0;
  // A period of 2^4 to 2^14 ticks keeps the run short.
  watchdog_control #(.SHIFT_REDUCE(10)) DUT (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rdq), .special_mode(sp), .stop_mode(stp), .pseudo_stop_select(ps),
    .background_debug(1'b0), .internal_rc_clock(rc), .oscillator_clock(osc), .oscillator_ok_status(ok),
    .flash_window_mode(fl[3]), .flash_rate_select(fl[2:0]), .wd_reset_q(wdr), .irq_q(irq));
  initial forever #12.5 ref_clk = ~ref_clk;
  // Counter clocks stay well below a quarter of the system clock: 8 and 10 cycles a period.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) rc <= ~rc;
    if (cyc % 5 == 4) osc <= ~osc;
    np <= np + (wdr === 1'b1);
    if (cyc == 20000)
    begin
      n_errors++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bus(input w, input r, input [7:0] a, input [7:0] dd);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wr_data <= dd;
    @(posedge ref_clk);
  endtask
  task idle(input integer k);
    repeat (k) bus(0, 0, 8'h00, 8'h00);
  endtask
  task wr(input [7:0] a, input [7:0] dd);
    bus(1, 0, a, dd);
  endtask
  task rd(input [7:0] a, input [7:0] x);
    bus(0, 1, a, 8'h00);
    idle(1);
    `CHK(rdq, x)
  endtask
  task rstart(input s, input [3:0] f);
    rst <= 1;
    sp <= s;
    fl <= f;
    idle(3);
    rst <= 0;
    idle(1);
  endtask
  task waitr(input integer lo, input integer hi);
    n = 0;
    while (wdr !== 1'b1 && n <= hi)
    begin
      idle(1);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask
  function integer per(input integer r, input integer s);
    per = (1 << (2 * r + 2)) * (s ? 10 : 8);
  endfunction
  initial
  begin
    d = $urandom(52);
    rstart(0, 4'h1);
    rd(`WD_CTL_OFF, 8'h01);
    waitr(96, 152);
    rstart(0, 4'h1);
    wr(`WD_CTL_OFF, 8'h23);
    rd(`WD_CTL_OFF, 8'h01);
    wr(`WD_CTL_OFF, 8'h00);
    rd(`WD_CTL_OFF, 8'h01);
    wr(`WD_CTL_OFF, 8'h86);
    rd(`WD_CTL_OFF, 8'h01);
    wr(`WD_CTL_OFF, 8'h40);
    rd(`WD_CTL_OFF, 8'h41);
    wr(`WD_CTL_OFF, 8'h00);
    rd(`WD_CTL_OFF, 8'h41);
    i = np;
    repeat (6)
    begin
      idle(80);
      wr(`WD_SVC_OFF, `WD_KEY_ARM);
      wr(`WD_SVC_OFF, `WD_KEY_FIRE);
    end
    idle(2);
    `CHK(np, i)
    rd(`WD_SVC_OFF, 8'h00);
    rd(8'h10, 8'h00);
    wr(`WD_MASK_OFF, 8'h02);
    wr(`WD_SVC_OFF, 8'h12);
    idle(1);
    `CHK(wdr, 1'b1)
    idle(2);
    `CHK(irq, 1'b1)
    rd(`WD_STAT_OFF, 8'h02);
    wr(`WD_STAT_OFF, 8'h02);
    idle(3);
    `CHK(irq, 1'b0)
    stp <= 1;
    i = np;
    idle(400);
    `CHK(np, i)
    stp <= 0;
    waitr(96, 160);
    // Rate 000 from flash leaves the watchdog off, so even a bad key is ignored.
    rstart(0, 4'h8);
    rd(`WD_CTL_OFF, 8'h80);
    i = np;
    wr(`WD_SVC_OFF, 8'h12);
    idle(300);
    `CHK(np, i)
    // Each restart comes well after the previous start, so a missing one times out early.
    rstart(0, 4'h9);
    rd(`WD_CTL_OFF, 8'h81);
    idle(80);
    wr(`WD_CTL_OFF, 8'h01);
    waitr(96, 152);
    rd(`WD_CTL_OFF, 8'h81);
    idle(80);
    wr(`WD_CTL_OFF, 8'h40);
    waitr(96, 152);
    rstart(1, 4'h0);
    wr(`WD_CFG_OFF, 8'h03);
    wr(`WD_CTL_OFF, 8'h01);
    ps <= 1;
    stp <= 1;
    waitr(144, 184);
    ps <= 0;
    stp <= 0;
    idle(100);
    rd(`WD_CFG_OFF, 8'h07);
    ok <= 0;
    waitr(120, 160);
    rd(`WD_CFG_OFF, 8'h03);
    ok <= 1;
    rstart(1, 4'h0);
    for (i = 0; i < 8; i++)
    begin
      // The first pass is a masked write that must leave window and rate alone.
      d = (i == 0) ? 8'h27 : $urandom;
      e = d[5] ? {e[7], d[6], 3'h0, e[2:0]} : {d[7], d[6], 3'h0, d[2:0]};
      wr(`WD_CTL_OFF, d);
      rd(`WD_CTL_OFF, e);
    end
    wr(`WD_CTL_OFF, 8'h81);
    wr(`WD_SVC_OFF, `WD_KEY_ARM);
    idle(1);
    `CHK(wdr, 1'b1)
    rd(`WD_STAT_OFF, 8'h04);
    wr(`WD_CTL_OFF, 8'h81);
    i = np;
    idle(112);
    wr(`WD_SVC_OFF, `WD_KEY_ARM);
    wr(`WD_SVC_OFF, `WD_KEY_FIRE);
    idle(3);
    `CHK(np, i)
    for (i = 1; i < 5; i++)
    begin
      rstart(1, 4'h0);
      wr(`WD_CFG_OFF, i % 2);
      wr(`WD_CTL_OFF, i);
      waitr(per(i, i % 2) - 16, per(i, i % 2) + 24);
    end
    finish_test;
  end
endmodule // tb_top
